// ### logic/alm_regs.vh
// Constants for the auxiliary level monitor: register addresses, fields,
// reset values and timing counts.
// Assumes a 200 MHz core clock and the serial control port of the device.
`ifndef ALM_REGS_VH
`define ALM_REGS_VH

// Register addresses on the serial control port
`define ALM_ADDR_CFG_A 8'hB2
`define ALM_ADDR_CFG_B 8'hB3
`define ALM_ADDR_RESULT 8'hB4
`define ALM_ADDR_CFG_C 8'hC0
`define ALM_ADDR_GEN_RESET 8'h01

// Reset values
`define ALM_CFG_A_RST 16'hFF00
`define ALM_CFG_B_RST 16'h0000
`define ALM_CFG_C_RST 16'h0001
`define ALM_RESULT_RST 8'h00

// Threshold word: high threshold upper byte, low threshold lower byte
`define ALM_THR_HI_MSB 15
`define ALM_THR_HI_LSB 8
`define ALM_THR_LO_MSB 7
`define ALM_THR_LO_LSB 0

// Option word fields
`define ALM_SEL_MSB 1
`define ALM_SEL_LSB 0
`define ALM_IRQ_HI_EN_BIT 2
`define ALM_IRQ_LO_EN_BIT 3
`define ALM_AUTO_RX_BIT 4
`define ALM_IVL_MSB 15
`define ALM_IVL_LSB 8

// Power-down control fields
`define ALM_PWR_XTAL_BIT 0
`define ALM_PWR_BIAS_BIT 1
`define ALM_PWR_ADC_BIT 2

// Input source codes
`define ALM_SRC_MONITOR 2'h0
`define ALM_SRC_FIRST_MICROPHONE_INPUT 2'h1
`define ALM_SRC_INPUT2 2'h2
`define ALM_SRC_DISCRIMINATOR_INPUT 2'h3

// Serial frame lengths in bits
`define ALM_ADDR_BITS 5'h08
`define ALM_WR_BITS 5'h18
`define ALM_RD_BITS 5'h10

// Timing
`define ALM_CLK_PERIOD_NS 5
`define ALM_IVL_UNIT_US_X10 208
// One interval unit of 20.8 us in 5 ns core clocks
`define ALM_IVL_UNIT_CYC 24'h001040
`define ALM_SAR_SETTLE_CYC 3'h4

`endif

// ### logic/alm_sar.v
// Successive approximation sequencer for the 8-bit monitor converter.
// Assumes an external comparator whose synchronised answer is high when
// the input is at or above the trial code, valid SETTLE cycles after it.
`timescale 1ns/100ps
`default_nettype none
`include "alm_regs.vh"

module alm_sar (
    // Clock and reset
    input wire core_clk_i,
    input wire nrst_i,
    // Control
    input wire start_i,
    input wire abort_i,
    input wire cmp_i,
    // Status and data
    output reg busy_o,
    output reg done_o,
    output reg [7:0] result_o,
    output reg [7:0] trial_o
);
    reg [7:0] bit_q;
    reg [2:0] wait_q;

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            result_o <= `ALM_RESULT_RST;
            trial_o <= 8'h00;
            bit_q <= 8'h00;
            wait_q <= 3'h0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                // Power removed: drop the trial, keep the last result
                busy_o <= 1'b0;
                trial_o <= 8'h00;
                bit_q <= 8'h00;
                wait_q <= 3'h0;
            end else if (!busy_o) begin
                if (start_i) begin
                    busy_o <= 1'b1;
                    bit_q <= 8'h80;
                    trial_o <= 8'h80;
                    wait_q <= `ALM_SAR_SETTLE_CYC;
                end
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else begin
                // Keep or drop the trial bit, then try the next one
                if (bit_q == 8'h01) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    result_o <= cmp_i ? trial_o : (trial_o & ~bit_q);
                end else begin
                    trial_o <= (cmp_i ? trial_o : (trial_o & ~bit_q))
                        | (bit_q >> 1);
                    bit_q <= bit_q >> 1;
                    wait_q <= `ALM_SAR_SETTLE_CYC;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/alm_top.v
// Auxiliary signal level monitor with its serial control port slave.
// Assumes host drives the serial clock at under 1/8 of the core clock and
// an external 8-bit DAC plus comparator around the selected input.
`timescale 1ns/100ps
`default_nettype none
`include "alm_regs.vh"

module alm_top #(
    parameter [23:0] IVL_UNIT_CYC = `ALM_IVL_UNIT_CYC
) (
    // Clock and reset
    input wire core_clk_i,
    input wire nrst_i,
    // Serial control port
    input wire ser_csn_i,
    input wire ser_sclk_i,
    input wire ser_cdata_i,
    output reg ser_rdata_o,
    output reg ser_rdata_oe_o,
    output reg irq_n_o,
    // Converter analogue side
    input wire adc_cmp_i,
    output reg [1:0] mon_sel_o,
    output reg [7:0] dac_code_o,
    output reg adc_pwr_o,
    // Wake-up requests
    output reg rx_wake_o,
    output reg mon_wake_o
);
    // Pin synchronisers
    reg csn_s1_q, csn_s2_q, sclk_s1_q, sclk_s2_q, sclk_s3_q;
    reg cdat_s1_q, cdat_s2_q, cmp_s1_q, cmp_s2_q;
    // Serial slave state
    reg [4:0] bitcnt_q;
    reg [23:0] shin_q;
    reg [7:0] shout_q;
    reg rd_q;
    // Registers
    reg [15:0] cfg_a_q, cfg_b_q, cfg_c_q;
    reg [7:0] result_q;
    // Interval timer
    reg [23:0] unit_q;
    reg [7:0] mult_q;
    reg start_q;

    wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
    wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
    wire [23:0] shin_d = {shin_q[22:0], cdat_s2_q};
    wire [4:0] bitcnt_d = bitcnt_q + 5'h01;
    wire [7:0] thr_hi = cfg_a_q[`ALM_THR_HI_MSB:`ALM_THR_HI_LSB];
    wire [7:0] thr_lo = cfg_a_q[`ALM_THR_LO_MSB:`ALM_THR_LO_LSB];
    wire run = cfg_c_q[`ALM_PWR_ADC_BIT] & cfg_c_q[`ALM_PWR_BIAS_BIT]
        & cfg_c_q[`ALM_PWR_XTAL_BIT];
    wire sar_busy, sar_done;
    wire [7:0] sar_result, sar_trial;
    wire gen_reset = sclk_rise && !csn_s2_q && bitcnt_d == `ALM_ADDR_BITS
        && shin_d[7:0] == `ALM_ADDR_GEN_RESET;
    wire res_read = sclk_rise && !csn_s2_q && bitcnt_d == `ALM_ADDR_BITS
        && shin_d[7:0] == `ALM_ADDR_RESULT;
    wire over_hi = sar_done && sar_result > thr_hi;
    wire under_lo = sar_done && sar_result < thr_lo;

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            csn_s1_q <= 1'b1;
            csn_s2_q <= 1'b1;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cdat_s1_q <= 1'b0;
            cdat_s2_q <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            csn_s1_q <= ser_csn_i;
            csn_s2_q <= csn_s1_q;
            sclk_s1_q <= ser_sclk_i;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cdat_s1_q <= ser_cdata_i;
            cdat_s2_q <= cdat_s1_q;
            cmp_s1_q <= adc_cmp_i;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // Serial slave and register file
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bitcnt_q <= 5'h00;
            shin_q <= 24'h000000;
            shout_q <= 8'h00;
            rd_q <= 1'b0;
            ser_rdata_o <= 1'b0;
            ser_rdata_oe_o <= 1'b0;
            cfg_a_q <= `ALM_CFG_A_RST;
            cfg_b_q <= `ALM_CFG_B_RST;
            cfg_c_q <= `ALM_CFG_C_RST;
        end else if (csn_s2_q) begin
            bitcnt_q <= 5'h00;
            rd_q <= 1'b0;
            ser_rdata_oe_o <= 1'b0;
        end else if (gen_reset) begin
            bitcnt_q <= bitcnt_d;
            cfg_a_q <= `ALM_CFG_A_RST;
            cfg_b_q <= `ALM_CFG_B_RST;
            cfg_c_q <= `ALM_CFG_C_RST;
        end else if (sclk_rise) begin
            shin_q <= shin_d;
            if (bitcnt_q != `ALM_WR_BITS) begin
                bitcnt_q <= bitcnt_d;
            end
            if (res_read) begin
                rd_q <= 1'b1;
                shout_q <= {result_q[6:0], 1'b0};
                ser_rdata_o <= result_q[7];
                ser_rdata_oe_o <= 1'b1;
            end else if (bitcnt_d == `ALM_RD_BITS && rd_q) begin
                ser_rdata_oe_o <= 1'b0;
            end else if (bitcnt_d == `ALM_WR_BITS && !rd_q) begin
                case (shin_d[23:16])
                    `ALM_ADDR_CFG_A: begin
                        cfg_a_q <= shin_d[15:0];
                    end
                    `ALM_ADDR_CFG_B: begin
                        cfg_b_q <= shin_d[15:0];
                    end
                    `ALM_ADDR_CFG_C: begin
                        cfg_c_q <= shin_d[15:0];
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sclk_fall && rd_q && ser_rdata_oe_o
                     && bitcnt_q != `ALM_ADDR_BITS) begin
            ser_rdata_o <= shout_q[7];
            shout_q <= {shout_q[6:0], 1'b0};
        end
    end

    // Interval timer, conversions and threshold events
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            unit_q <= 24'h000000;
            mult_q <= 8'h00;
            start_q <= 1'b0;
            result_q <= `ALM_RESULT_RST;
            irq_n_o <= 1'b1;
            rx_wake_o <= 1'b0;
            mon_wake_o <= 1'b0;
            mon_sel_o <= `ALM_SRC_MONITOR;
            dac_code_o <= 8'h00;
            adc_pwr_o <= 1'b0;
        end else begin
            mon_sel_o <= cfg_b_q[`ALM_SEL_MSB:`ALM_SEL_LSB];
            dac_code_o <= sar_trial;
            adc_pwr_o <= run;
            start_q <= 1'b0;
            if (!run || gen_reset) begin
                unit_q <= 24'h000000;
                mult_q <= 8'h00;
            end else if (unit_q != IVL_UNIT_CYC - 24'h000001) begin
                unit_q <= unit_q + 24'h000001;
            end else begin
                unit_q <= 24'h000000;
                if (mult_q != cfg_b_q[`ALM_IVL_MSB:`ALM_IVL_LSB]) begin
                    mult_q <= mult_q + 8'h01;
                end else begin
                    mult_q <= 8'h00;
                    start_q <= ~sar_busy;
                end
            end
            if (sar_done) begin
                result_q <= sar_result;
            end
            // Event set wins over a read of the result
            if ((over_hi && cfg_b_q[`ALM_IRQ_HI_EN_BIT])
                || (under_lo && cfg_b_q[`ALM_IRQ_LO_EN_BIT])) begin
                irq_n_o <= 1'b0;
            end else if (res_read || gen_reset) begin
                irq_n_o <= 1'b1;
            end
            if (over_hi && cfg_b_q[`ALM_IRQ_HI_EN_BIT]) begin
                mon_wake_o <= 1'b1;
            end else if (gen_reset || !cfg_b_q[`ALM_IRQ_HI_EN_BIT]) begin
                mon_wake_o <= 1'b0;
            end
            if (over_hi && cfg_b_q[`ALM_AUTO_RX_BIT]
                && cfg_b_q[`ALM_SEL_MSB:`ALM_SEL_LSB]
                == `ALM_SRC_DISCRIMINATOR_INPUT) begin
                rx_wake_o <= 1'b1;
            end else if (gen_reset || !cfg_b_q[`ALM_AUTO_RX_BIT]) begin
                rx_wake_o <= 1'b0;
            end
        end
    end

    alm_sar u_sar (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .start_i(start_q),
        .abort_i(~run),
        .cmp_i(cmp_s2_q),
        .busy_o(sar_busy),
        .done_o(sar_done),
        .result_o(sar_result),
        .trial_o(sar_trial)
    );
endmodule
`default_nettype wire

// ### sim/alm_top_sva.sv
// Checker for the level monitor, seeing only the top module's ports.
// Assumes one core clock domain and an active low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module alm_top_sva #(
    parameter logic [23:0] IVL_UNIT_CYC = 24'h001040
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Serial port
    input wire logic ser_csn_i,
    input wire logic ser_sclk_i,
    input wire logic ser_cdata_i,
    input wire logic ser_rdata_o,
    input wire logic ser_rdata_oe_o,
    input wire logic irq_n_o,
    // Converter and wake
    input wire logic adc_cmp_i,
    input wire logic [1:0] mon_sel_o,
    input wire logic [7:0] dac_code_o,
    input wire logic adc_pwr_o,
    input wire logic rx_wake_o,
    input wire logic mon_wake_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    oe_idle_a: assert property (ser_csn_i [*6] |-> !ser_rdata_oe_o)
        else $error("read drive while deselected");
    oe_sel_a: assert property ($rose(ser_rdata_oe_o) |-> !ser_csn_i)
        else $error("read drive without select");
    hi_irq_a: assert property ($rose(mon_wake_o) |-> ##[0:1] !irq_n_o)
        else $error("wake without interrupt");
    wake_pwr_a: assert property (
        $rose(mon_wake_o) |-> $past(adc_pwr_o))
        else $error("wake while unpowered");
    rx_src_a: assert property (
        $rose(rx_wake_o) |-> mon_sel_o == 2'h3)
        else $error("receive wake from wrong source");
    irq_pwr_a: assert property (
        $fell(irq_n_o) |-> $past(adc_pwr_o))
        else $error("interrupt while unpowered");
    dac_pwr_a: assert property (
        $changed(dac_code_o) && dac_code_o != 8'h00 |-> $past(adc_pwr_o))
        else $error("conversion while unpowered");
    sar_step_a: assert property (
        dac_code_o == 8'h80 && $past(dac_code_o) != 8'h80
        |-> ##[1:6] dac_code_o[6] && dac_code_o[5:0] == 6'h00)
        else $error("second trial code wrong");
    cover property ($rose(mon_wake_o));
    cover property ($rose(rx_wake_o));
    cover property ($fell(irq_n_o));
endmodule
bind alm_top alm_top_sva #(.IVL_UNIT_CYC(IVL_UNIT_CYC)) chk (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ser_csn_i(ser_csn_i),
    .ser_sclk_i(ser_sclk_i), .ser_cdata_i(ser_cdata_i),
    .ser_rdata_o(ser_rdata_o), .ser_rdata_oe_o(ser_rdata_oe_o),
    .irq_n_o(irq_n_o), .adc_cmp_i(adc_cmp_i), .mon_sel_o(mon_sel_o),
    .dac_code_o(dac_code_o), .adc_pwr_o(adc_pwr_o), .rx_wake_o(rx_wake_o),
    .mon_wake_o(mon_wake_o));
`default_nettype wire

// ### sim/alm_host.sv
// Host model driving the serial control port, MSB first.
// Assumes the serial clock halves last well over 8 core clocks.
`timescale 1ns/100ps
`default_nettype none
module alm_host (
    // Clock and read side
    input wire logic clk_i,
    input wire logic rdata_i,
    input wire logic oe_i,
    // Serial outputs
    output logic csn_o,
    output logic sclk_o,
    output logic cdata_o
);
    localparam int HB = 10;
    initial begin
        csn_o = 1'b1;
        sclk_o = 1'b0;
        cdata_o = 1'b0;
    end
    // Frame of n bits; data sampled at each serial clock rise
    task automatic xfer(input logic [7:0] a, input logic [15:0] wd,
        input int n, output logic [15:0] rd, output logic oe);
        logic [23:0] sh;
        sh = {a, wd};
        rd = 16'h0000;
        oe = 1'b0;
        @(posedge clk_i) csn_o <= 1'b0;
        repeat (HB) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            sclk_o <= 1'b0;
            cdata_o <= sh[23 - i];
            repeat (HB) @(posedge clk_i);
            sclk_o <= 1'b1;
            rd = {rd[14:0], rdata_i};
            if (i == 8) oe = oe_i;
            repeat (HB) @(posedge clk_i);
        end
        sclk_o <= 1'b0;
        repeat (HB) @(posedge clk_i);
        csn_o <= 1'b1;
        cdata_o <= ~cdata_o;
        repeat (HB) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### sim/alm_top_tb.sv
// Testbench for the level monitor: threshold table, then resets and timing.
// Assumes an ideal comparator on the trial code and the host model.
`timescale 1ns/100ps
`default_nettype none
module alm_top_tb;
    localparam int IVL = 60;
    typedef struct {logic [7:0] hi, lo, opt, lv; logic [2:0] ex;} alm_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmp = 1'b0;
    logic [7:0] lvl = 8'h00;
    logic [7:0] dac_p = 8'h00;
    logic [15:0] rd;
    logic oe_s;
    int n_errors = 0;
    int checks = 0;
    int n;
    wire csn, sclk, cdata, rdata, oe, irq_n, pwr, rxw, mw;
    wire [1:0] sel;
    wire [7:0] dac;
    // Every row keeps the low threshold below the high one
    alm_row_t rows [6] = '{'{8'h80, 8'h20, 8'h04, 8'h90, 3'b010},
        '{8'h80, 8'h20, 8'h08, 8'h10, 3'b000},
        '{8'h80, 8'h20, 8'h13, 8'h90, 3'b101},
        '{8'h80, 8'h20, 8'h12, 8'h90, 3'b100},
        '{8'h80, 8'h20, 8'h0C, 8'h80, 3'b100},
        '{8'h80, 8'h20, 8'h0C, 8'h20, 3'b100}};
    always #2.5 clk = ~clk;
    always @(posedge clk) cmp <= (lvl >= dac);
    always @(posedge clk) dac_p <= dac;
    alm_host host (.clk_i(clk), .rdata_i(rdata), .oe_i(oe), .csn_o(csn),
        .sclk_o(sclk), .cdata_o(cdata));
    alm_top #(.IVL_UNIT_CYC(24'(IVL))) dut (.core_clk_i(clk), .nrst_i(nrst),
        .ser_csn_i(csn), .ser_sclk_i(sclk), .ser_cdata_i(cdata),
        .ser_rdata_o(rdata), .ser_rdata_oe_o(oe), .irq_n_o(irq_n),
        .adc_cmp_i(cmp), .mon_sel_o(sel), .dac_code_o(dac),
        .adc_pwr_o(pwr), .rx_wake_o(rxw), .mon_wake_o(mw));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer(a, d, 24, rd, oe_s);
    endtask
    task automatic rdb(input logic [7:0] a);
        host.xfer(a, 16'h0000, 16, rd, oe_s);
    endtask
    task automatic span(output int c);
        do begin
            @(posedge clk);
        end while (!(dac == 8'h80 && dac_p != 8'h80));
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!(dac == 8'h80 && dac_p != 8'h80));
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({irq_n, pwr, rxw, mw}, 4'b1000);
        wr(8'hC0, 16'h0003);
        chk(pwr, 1'b0);
        wr(8'hC0, 16'h0007);
        chk(pwr, 1'b1);
        rdb(8'hB2);
        chk(oe_s, 1'b0);
        $display("power and access done");
        foreach (rows[i]) begin
            @(posedge clk) lvl <= rows[i].lv;
            wr(8'hB2, {rows[i].hi, rows[i].lo});
            wr(8'hB3, {8'h00, rows[i].opt});
            repeat (4 * IVL) @(posedge clk);
            chk(sel, rows[i].opt[1:0]);
            chk({irq_n, mw, rxw}, rows[i].ex);
            rdb(8'hB4);
            chk({oe_s, rd[7:0]}, {1'b1, rows[i].lv});
            wr(8'hB3, 16'h0000);
            rdb(8'hB4);
            chk({irq_n, mw, rxw}, 3'b100);
            $display("row %0d done", i);
        end
        host.xfer(8'h01, 16'h0000, 8, rd, oe_s);
        chk({irq_n, pwr}, 2'b10);
        @(posedge clk) lvl <= 8'h33;
        wr(8'hC0, 16'h0007);
        span(n);
        chk(16'(n), 16'(IVL));
        wr(8'hB3, 16'h0100);
        span(n);
        span(n);
        chk(16'(n), 16'(2 * IVL));
        $display("interval done");
        wr(8'hB2, 16'h2010);
        wr(8'hB3, 16'h0004);
        repeat (4 * IVL) @(posedge clk);
        chk({irq_n, mw}, 2'b01);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({irq_n, pwr, rxw, mw, dac}, {4'b1000, 8'h00});
        wr(8'hC0, 16'h0007);
        repeat (2 * IVL) @(posedge clk);
        rdb(8'hB4);
        chk({oe_s, rd[7:0]}, {1'b1, 8'h33});
        chk({irq_n, mw, sel}, {2'b10, 2'h0});
        $display("reset done");
        conclude();
    end
endmodule
`default_nettype wire
